/* include/lswhw_pkg.sv */
/*
  constants, object map and state codes for the limit switch reaction
  and hardware information block.
  assumes one system clock, synchronous active-high reset, and an
  object dictionary access port driven by the fieldbus slave logic.
*/
package lswhw_pkg;
  localparam logic [15:0] IDX_LIMIT_REACT = 16'h3701;
  localparam logic [15:0] IDX_HW_INFO     = 16'h4012;
  localparam logic [15:0] IDX_HW_CONFIG   = 16'h4013;
  localparam logic [15:0] IDX_OP_COND     = 16'h4014;
  localparam logic [7:0]  SUB_COUNT       = 8'h00;
  localparam logic [7:0]  SUB_1           = 8'h01;
  localparam logic [7:0]  SUB_2           = 8'h02;
  localparam logic [7:0]  SUB_3           = 8'h03;
  localparam logic [7:0]  SUB_4           = 8'h04;
  localparam logic [7:0]  SUB_5           = 8'h05;
  localparam logic [7:0]  HW_INFO_COUNT   = 8'h01;
  localparam logic [7:0]  HW_CONFIG_COUNT = 8'h01;
  localparam logic [7:0]  OP_COND_COUNT   = 8'h05;
  localparam logic [15:0] LIMIT_REACT_RST = 16'hffff;
  localparam logic [31:0] HW_CONFIG_RST   = 32'h00000000;
  localparam logic [15:0] CODE_NONE       = 16'hffff;
  localparam logic [15:0] CODE_SLOW_DIS   = 16'h0001;
  localparam logic [15:0] CODE_QUICK_DIS  = 16'h0002;
  localparam logic [15:0] CODE_SLOW_QS    = 16'h0005;
  localparam logic [15:0] CODE_QUICK_QS   = 16'h0006;
  localparam int          CW_QUICK_STOP   = 2;
  localparam logic [1:0]  ERR_NONE        = 2'h0;
  localparam logic [1:0]  ERR_NO_OBJECT   = 2'h1;
  localparam logic [1:0]  ERR_READ_ONLY   = 2'h2;

  typedef enum logic [4:0] {
    ST_IDLE      = 5'b00001,
    ST_BRAKE_DIS = 5'b00010,
    ST_BRAKE_QS  = 5'b00100,
    ST_DISABLED  = 5'b01000,
    ST_QUICKSTOP = 5'b10000
  } lswhw_state_t;

  typedef enum logic [1:0] {
    RAMP_NONE  = 2'h0,
    RAMP_SLOW  = 2'h1,
    RAMP_QUICK = 2'h2
  } lswhw_ramp_t;
endpackage

/* rtl/lswhw_reaction.sv */
/*
  limit switch reaction sequencer: picks the ramp and follow-up state.
  assumes ramp_done comes from the ramp generator of the drive and that
  the drive state machine acts on the request outputs.
*/
`timescale 1ns/10ps
module lswhw_reaction (
  input  wire logic        ref_clk,       // system clock
  input  wire logic        rst,           // sync reset, high
  input  wire logic [15:0] select,        // reaction code
  input  wire logic        limit_hit,     // limit switch passed, pulse
  input  wire logic        ramp_done,     // motor stopped, pulse or level
  input  wire logic        quick_stop_cw, // quick-stop control bit, written value
  output logic [1:0]       ramp_sel,      // ramp to brake on
  output logic             warn_q,        // status warning flag
  output logic             req_disabled,  // request switch on disabled
  output logic             req_quickstop, // request quick stop active
  output logic             resume         // back to operation enabled, pulse
);
  lswhw_pkg::lswhw_state_t state_q, state_d;
  logic [1:0] ramp_q, ramp_d;
  logic       warn_d;
  logic       qs_prev_q, qs_prev_d;
  logic       qs_armed_q, qs_armed_d;

  // next state; decode picks ramp and target from the code
  always_comb begin
    state_d    = state_q;
    ramp_d     = ramp_q;
    warn_d     = warn_q;
    qs_prev_d  = quick_stop_cw;
    qs_armed_d = qs_armed_q;
    resume     = 1'b0;
    if (limit_hit) begin
      warn_d = 1'b1;
    end
    case (state_q)
      lswhw_pkg::ST_IDLE: begin
        if (limit_hit) begin
          case (select)
            lswhw_pkg::CODE_SLOW_DIS: begin
              state_d = lswhw_pkg::ST_BRAKE_DIS;
              ramp_d  = lswhw_pkg::RAMP_SLOW;
            end
            lswhw_pkg::CODE_QUICK_DIS: begin
              state_d = lswhw_pkg::ST_BRAKE_DIS;
              ramp_d  = lswhw_pkg::RAMP_QUICK;
            end
            lswhw_pkg::CODE_SLOW_QS: begin
              state_d = lswhw_pkg::ST_BRAKE_QS;
              ramp_d  = lswhw_pkg::RAMP_SLOW;
            end
            lswhw_pkg::CODE_QUICK_QS: begin
              state_d = lswhw_pkg::ST_BRAKE_QS;
              ramp_d  = lswhw_pkg::RAMP_QUICK;
            end
            default: begin
              state_d = lswhw_pkg::ST_IDLE; // -1 and unknown codes: no action
            end
          endcase
        end
      end
      lswhw_pkg::ST_BRAKE_DIS: begin
        if (ramp_done) begin
          state_d = lswhw_pkg::ST_DISABLED;
          ramp_d  = lswhw_pkg::RAMP_NONE;
        end
      end
      lswhw_pkg::ST_BRAKE_QS: begin
        if (ramp_done) begin
          state_d    = lswhw_pkg::ST_QUICKSTOP;
          ramp_d     = lswhw_pkg::RAMP_NONE;
          qs_armed_d = 1'b0;
        end
      end
      lswhw_pkg::ST_DISABLED: begin
        // held until the drive state machine clears the condition by reset
        state_d = lswhw_pkg::ST_DISABLED;
      end
      lswhw_pkg::ST_QUICKSTOP: begin
        // the bit stays as written; only a 0 then 1 sequence resumes
        if (!quick_stop_cw) begin
          qs_armed_d = 1'b1;
        end
        if (qs_armed_q && quick_stop_cw && !qs_prev_q) begin
          state_d    = lswhw_pkg::ST_IDLE;
          qs_armed_d = 1'b0;
          warn_d     = limit_hit;
          resume     = 1'b1;
        end
      end
      default: begin
        state_d = lswhw_pkg::ST_IDLE;
        ramp_d  = lswhw_pkg::RAMP_NONE;
      end
    endcase
  end

  // registers only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q    <= lswhw_pkg::ST_IDLE;
      ramp_q     <= lswhw_pkg::RAMP_NONE;
      warn_q     <= 1'b0;
      qs_prev_q  <= 1'b1;
      qs_armed_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      ramp_q     <= ramp_d;
      warn_q     <= warn_d;
      qs_prev_q  <= qs_prev_d;
      qs_armed_q <= qs_armed_d;
    end
  end

  assign ramp_sel      = ramp_q;
  assign req_disabled  = (state_q == lswhw_pkg::ST_DISABLED);
  assign req_quickstop = (state_q == lswhw_pkg::ST_QUICKSTOP); // motor stays energized
endmodule // lswhw_reaction

/* rtl/lswhw_top.sv */
/*
  object dictionary entries for the limit switch reaction selector,
  hardware information, hardware configuration and operating conditions.
  assumes the fieldbus slave presents one index/subindex access at a
  time as a one-cycle strobe, and that measurements arrive already
  scaled from the measurement front ends.
*/
`timescale 1ns/10ps
module lswhw_top (
  input  wire logic        ref_clk,              // system clock, 100 MHz
  input  wire logic        rst,                  // sync reset, high
  input  wire logic        od_req,               // access strobe, one cycle
  input  wire logic        od_write,             // 1 write, 0 read
  input  wire logic [15:0] od_index,             // object index
  input  wire logic [7:0]  od_sub,               // subindex
  input  wire logic [31:0] od_wdata,             // write data, low 16 bits for the selector, all 32 for config
  output logic             od_ack,               // answer strobe
  output logic [1:0]       od_err,               // answer status
  output logic [31:0]      od_rdata,             // read data
  input  wire logic [31:0] eeprom_size,          // eeprom bytes, 0 if absent
  input  wire logic [31:0] power_supply_voltage, // millivolts, signed
  input  wire logic [31:0] logic_supply_voltage, // millivolts, signed
  input  wire logic [31:0] board_temperature,    // tenths degree, signed
  input  wire logic [31:0] motor_temperature,    // tenths degree, signed
  input  wire logic [31:0] cpu_temperature,      // tenths degree, signed
  input  wire logic        limit_hit,            // limit switch passed, pulse
  input  wire logic        ramp_done,            // braking finished
  input  wire logic        quick_stop_cw,        // quick-stop control bit
  output logic [1:0]       ramp_sel,             // ramp to brake on
  output logic             status_warning,       // status warning flag
  output logic             req_disabled,         // request switch on disabled
  output logic             req_quickstop,        // request quick stop active
  output logic             resume_enabled,       // return to operation enabled
  output logic [31:0]      hardware_config_word, // config word, no function
  output logic [31:0]      tx_power_mv,          // process data image
  output logic [31:0]      tx_logic_mv           // process data image
);
  logic [15:0] limit_reaction_select_q, limit_reaction_select_d;
  logic [31:0] hw_config_word_q, hw_config_word_d;
  logic        ack_q, ack_d;
  logic [1:0]  err_q, err_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] txp_q, txp_d, txl_q, txl_d;

  // true when the access names a write-capable entry
  function automatic logic is_writable(input logic [15:0] idx, input logic [7:0] sub);
    is_writable = (idx == lswhw_pkg::IDX_LIMIT_REACT) ||
                  (idx == lswhw_pkg::IDX_HW_CONFIG && sub == lswhw_pkg::SUB_1);
  endfunction

  // count byte in low bits, upper bits zero
  function automatic logic [31:0] count_word(input logic [7:0] n);
    count_word = {24'h000000, n};
  endfunction

  lswhw_reaction u_react (
    .ref_clk       (ref_clk),
    .rst           (rst),
    .select        (limit_reaction_select_q),
    .limit_hit     (limit_hit),
    .ramp_done     (ramp_done),
    .quick_stop_cw (quick_stop_cw),
    .ramp_sel      (ramp_sel),
    .warn_q        (status_warning),
    .req_disabled  (req_disabled),
    .req_quickstop (req_quickstop),
    .resume        (resume_enabled)
  );

  // access decode; answer one cycle after the strobe
  always_comb begin
    limit_reaction_select_d = limit_reaction_select_q;
    hw_config_word_d        = hw_config_word_q;
    ack_d                   = od_req;
    err_d                   = lswhw_pkg::ERR_NONE;
    rdata_d                 = rdata_q;
    if (od_req) begin
      rdata_d = 32'h00000000;
      case (od_index)
        lswhw_pkg::IDX_LIMIT_REACT: begin
          // sign extended so -1 reads as all ones
          rdata_d = {{16{limit_reaction_select_q[15]}}, limit_reaction_select_q};
        end
        lswhw_pkg::IDX_HW_INFO: begin
          case (od_sub)
            lswhw_pkg::SUB_COUNT: rdata_d = count_word(lswhw_pkg::HW_INFO_COUNT);
            lswhw_pkg::SUB_1:     rdata_d = eeprom_size;
            default:              err_d   = lswhw_pkg::ERR_NO_OBJECT;
          endcase
        end
        lswhw_pkg::IDX_HW_CONFIG: begin
          case (od_sub)
            lswhw_pkg::SUB_COUNT: rdata_d = count_word(lswhw_pkg::HW_CONFIG_COUNT);
            lswhw_pkg::SUB_1:     rdata_d = hw_config_word_q;
            default:              err_d   = lswhw_pkg::ERR_NO_OBJECT;
          endcase
        end
        lswhw_pkg::IDX_OP_COND: begin
          case (od_sub)
            lswhw_pkg::SUB_COUNT: rdata_d = count_word(lswhw_pkg::OP_COND_COUNT);
            lswhw_pkg::SUB_1:     rdata_d = power_supply_voltage;
            lswhw_pkg::SUB_2:     rdata_d = logic_supply_voltage;
            lswhw_pkg::SUB_3:     rdata_d = board_temperature;
            lswhw_pkg::SUB_4:     rdata_d = motor_temperature;
            lswhw_pkg::SUB_5:     rdata_d = cpu_temperature;
            default:              err_d   = lswhw_pkg::ERR_NO_OBJECT;
          endcase
        end
        default: begin
          err_d = lswhw_pkg::ERR_NO_OBJECT;
        end
      endcase
      if (od_write && err_d == lswhw_pkg::ERR_NONE) begin
        // read-only entries refuse writes and keep their value
        if (!is_writable(od_index, od_sub)) begin
          err_d = lswhw_pkg::ERR_READ_ONLY;
        end else if (od_index == lswhw_pkg::IDX_LIMIT_REACT) begin
          limit_reaction_select_d = od_wdata[15:0];
        end else begin
          hw_config_word_d = od_wdata;
        end
        rdata_d = 32'h00000000;
      end
    end
  end

  // transmit process data image, refreshed every cycle
  always_comb begin
    txp_d = power_supply_voltage;
    txl_d = logic_supply_voltage;
  end

  // registers only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      limit_reaction_select_q <= lswhw_pkg::LIMIT_REACT_RST;
      hw_config_word_q        <= lswhw_pkg::HW_CONFIG_RST;
      ack_q                   <= 1'b0;
      err_q                   <= lswhw_pkg::ERR_NONE;
      rdata_q                 <= 32'h00000000;
      txp_q                   <= 32'h00000000;
      txl_q                   <= 32'h00000000;
    end else begin
      limit_reaction_select_q <= limit_reaction_select_d;
      hw_config_word_q        <= hw_config_word_d;
      ack_q                   <= ack_d;
      err_q                   <= err_d;
      rdata_q                 <= rdata_d;
      txp_q                   <= txp_d;
      txl_q                   <= txl_d;
    end
  end

  assign od_ack               = ack_q;
  assign od_err               = err_q;
  assign od_rdata             = rdata_q;
  assign hardware_config_word = hw_config_word_q;
  assign tx_power_mv          = txp_q;
  assign tx_logic_mv          = txl_q;
endmodule // lswhw_top

/* tb/lswhw_properties.sv */
/* port checker for lswhw_top.
   assumes one clock and the synchronous high reset of the top. */
`timescale 1ns/10ps
module lswhw_properties (
  input wire logic        ref_clk,              // clock
  input wire logic        rst,                  // reset
  input wire logic        od_req,               // strobe
  input wire logic        od_write,             // write flag
  input wire logic [15:0] od_index,             // index
  input wire logic [7:0]  od_sub,               // subindex
  input wire logic        od_ack,               // answer
  input wire logic [1:0]  od_err,               // status
  input wire logic [31:0] od_rdata,             // read data
  input wire logic [31:0] power_supply_voltage, // supply
  input wire logic        limit_hit,            // limit event
  input wire logic        quick_stop_cw,        // control bit
  input wire logic [1:0]  ramp_sel,             // ramp
  input wire logic        status_warning,       // warning
  input wire logic        req_disabled,         // disabled request
  input wire logic        req_quickstop,        // quick stop request
  input wire logic        resume_enabled,       // resume pulse
  input wire logic [31:0] hardware_config_word, // config copy
  input wire logic [31:0] tx_power_mv           // process image
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // answer timing and the object map
  chk_ack_next_cycle: assert property (od_req |=> od_ack) else $error("no answer");
  chk_ack_no_req: assert property (!od_req |=> !od_ack) else $error("stray answer");
  chk_ro_refused: assert property (od_req && od_write && od_index == lswhw_pkg::IDX_HW_INFO
    && od_sub == lswhw_pkg::SUB_1 |=> od_err == lswhw_pkg::ERR_READ_ONLY)
    else $error("ro write taken");
  chk_count_read: assert property (od_req && !od_write && od_index == lswhw_pkg::IDX_OP_COND
    && od_sub == lswhw_pkg::SUB_COUNT |=> od_rdata == 32'h00000005)
    else $error("bad count");
  chk_power_read: assert property (od_req && !od_write && od_index == lswhw_pkg::IDX_OP_COND
    && od_sub == lswhw_pkg::SUB_1 |=> od_rdata == $past(power_supply_voltage))
    else $error("bad supply");
  chk_tx_image: assert property (!$past(rst) |-> tx_power_mv == $past(power_supply_voltage))
    else $error("bad image");
  chk_cfg_reset: assert property ($past(rst) |-> hardware_config_word == 32'h00000000)
    else $error("config not zero");
  // reaction sequencing
  chk_warn_set: assert property (limit_hit |=> status_warning) else $error("no warning");
  chk_resume_gate: assert property (resume_enabled |-> quick_stop_cw && req_quickstop)
    else $error("bad resume");
  chk_qs_no_ramp: assert property (req_quickstop |-> ramp_sel == 2'h0)
    else $error("ramp in quick stop");
  chk_dis_held: assert property (req_disabled |=> req_disabled) else $error("disabled lost");
  cover property (limit_hit);
  cover property (resume_enabled);
  cover property (od_ack && od_err == lswhw_pkg::ERR_NO_OBJECT);
endmodule // lswhw_properties
bind lswhw_top lswhw_properties u_chk (.ref_clk, .rst, .od_req, .od_write, .od_index, .od_sub,
  .od_ack, .od_err, .od_rdata, .power_supply_voltage, .limit_hit, .quick_stop_cw, .ramp_sel,
  .status_warning, .req_disabled, .req_quickstop, .resume_enabled, .hardware_config_word,
  .tx_power_mv);

/* tb/lswhw_master.sv */
/* fieldbus master model: one strobe per access, plus the quick-stop bit.
   assumes the answer strobe follows the request by one cycle. */
`timescale 1ns/10ps
module lswhw_master (
  input  wire logic        ref_clk,      // clock
  input  wire logic        od_ack,       // answer
  input  wire logic [1:0]  od_err,       // status
  input  wire logic [31:0] od_rdata,     // read data
  output logic             od_req,       // strobe
  output logic             od_write,     // write flag
  output logic [15:0]      od_index,     // index
  output logic [7:0]       od_sub,       // subindex
  output logic [31:0]      od_wdata,     // write data
  output logic             quick_stop_cw // control bit
);
  initial begin
    od_req = 1'b0;
    od_write = 1'b0;
    od_index = 16'h0000;
    od_sub = 8'h00;
    od_wdata = 32'h00000000;
    quick_stop_cw = 1'b1;
  end
  // index and write data are inverted on release so a stale value never looks valid
  task automatic access(input logic w, input logic [15:0] i, input logic [7:0] s,
                        input logic [31:0] d, output logic [1:0] e, output logic [31:0] r);
    @(posedge ref_clk) #1;
    od_req = 1'b1;
    od_write = w;
    od_index = i;
    od_sub = s;
    od_wdata = d;
    @(posedge ref_clk) #1;
    od_req = 1'b0;
    od_index = ~i;
    od_wdata = ~d;
    e = od_ack ? od_err : 2'h3;
    r = od_rdata;
  endtask
  // control bit to zero, then back to one
  task automatic resume();
    @(posedge ref_clk) #1;
    quick_stop_cw = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 quick_stop_cw = 1'b1;
  endtask
endmodule // lswhw_master

/* tb/test_lswhw_top.sv */
/* testbench for lswhw_top: object accesses and limit reactions.
   assumes the master model owns the access port and the control bit. */
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR %0t mismatch %h %h", $time, a, b); end end
module test_lswhw_top;
  logic        ref_clk, rst, limit_hit, ramp_done, od_req, od_write, od_ack, quick_stop_cw;
  logic        status_warning, req_disabled, req_quickstop, resume_enabled;
  logic [1:0]  od_err, ramp_sel;
  logic [7:0]  od_sub;
  logic [15:0] od_index;
  logic [31:0] od_wdata, od_rdata, eeprom_size, hardware_config_word, tx_power_mv, tx_logic_mv;
  logic [31:0] meas [5];
  logic [15:0] codes [7] = '{16'hffff, 16'h0001, 16'h0002, 16'h0005, 16'h0006, 16'h0003, 16'h0000};
  int          num_errors = 0, check_count = 0, cycles = 0;
  lswhw_master u_mst (.ref_clk, .od_ack, .od_err, .od_rdata, .od_req, .od_write, .od_index,
    .od_sub, .od_wdata, .quick_stop_cw);
  lswhw_top DUT (.ref_clk, .rst, .od_req, .od_write, .od_index, .od_sub, .od_wdata, .od_ack,
    .od_err, .od_rdata, .eeprom_size, .power_supply_voltage(meas[0]),
    .logic_supply_voltage(meas[1]), .board_temperature(meas[2]), .motor_temperature(meas[3]),
    .cpu_temperature(meas[4]), .limit_hit, .ramp_done, .quick_stop_cw, .ramp_sel,
    .status_warning, .req_disabled, .req_quickstop, .resume_enabled, .hardware_config_word,
    .tx_power_mv, .tx_logic_mv);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // a hung handshake ends the run here
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one access with its expected status and read data
  task automatic op(input logic w, input logic [15:0] i, input logic [7:0] s,
                    input logic [31:0] d, input logic [1:0] ee, input logic [31:0] er);
    logic [1:0]  e;
    logic [31:0] r;
    u_mst.access(w, i, s, d, e, r);
    `CHK(e, ee)
    if (ee === lswhw_pkg::ERR_NONE) `CHK(r, er)
  endtask
  // fresh reset, set the code, pass the switch, finish braking
  task automatic react(input logic [15:0] c);
    logic [1:0] rs;
    logic       qs, seen;
    qs = (c == lswhw_pkg::CODE_SLOW_QS || c == lswhw_pkg::CODE_QUICK_QS);
    rs = (c == lswhw_pkg::CODE_SLOW_DIS || c == lswhw_pkg::CODE_SLOW_QS) ? 2'h1 :
         (c == lswhw_pkg::CODE_QUICK_DIS || c == lswhw_pkg::CODE_QUICK_QS) ? 2'h2 : 2'h0;
    seen = 1'b0;
    @(posedge ref_clk) #1 rst = 1'b1;
    @(posedge ref_clk) #1 rst = 1'b0;
    op(1'b1, lswhw_pkg::IDX_LIMIT_REACT, 8'h00, {16'ha5a5, c}, 2'h0, 32'h0);
    @(posedge ref_clk) #1 limit_hit = 1'b1;
    @(posedge ref_clk) #1 limit_hit = 1'b0;
    `CHK(status_warning, 1'b1)
    `CHK(ramp_sel, rs)
    ramp_done = 1'b1;
    @(posedge ref_clk) #1 ramp_done = 1'b0;
    `CHK(req_disabled, rs != 2'h0 && !qs)
    `CHK(req_quickstop, qs)
    `CHK(ramp_sel, 2'h0)
    if (qs) begin
      // the resume pulse is combinational and gone by the edge after the
      // rising control bit, so it is watched on falling edges while it stands
      fork
        u_mst.resume();
        repeat (5) @(negedge ref_clk) seen |= resume_enabled;
      join
      `CHK(seen, 1'b1)
      `CHK(req_quickstop, 1'b0)
      `CHK(status_warning, 1'b0)
    end
  endtask
  initial begin
    rst = 1'b1;
    limit_hit = 1'b0;
    ramp_done = 1'b0;
    eeprom_size = 32'h00000000;
    foreach (meas[k]) meas[k] = 32'hfffff000 | 32'(k * 16 + 3);
    repeat (8) @(posedge ref_clk);
    #1 rst = 1'b0;
    op(1'b0, lswhw_pkg::IDX_LIMIT_REACT, 8'h00, 32'h0, 2'h0, 32'hffffffff);
    op(1'b0, lswhw_pkg::IDX_HW_INFO, 8'h00, 32'h0, 2'h0, 32'h00000001);
    op(1'b0, lswhw_pkg::IDX_HW_CONFIG, 8'h00, 32'h0, 2'h0, 32'h00000001);
    op(1'b0, lswhw_pkg::IDX_OP_COND, 8'h00, 32'h0, 2'h0, 32'h00000005);
    op(1'b0, lswhw_pkg::IDX_HW_CONFIG, 8'h01, 32'h0, 2'h0, 32'h00000000);
    op(1'b0, lswhw_pkg::IDX_HW_INFO, 8'h01, 32'h0, 2'h0, 32'h00000000);
    eeprom_size = 32'h00008000;
    op(1'b0, lswhw_pkg::IDX_HW_INFO, 8'h01, 32'h0, 2'h0, 32'h00008000);
    op(1'b1, lswhw_pkg::IDX_HW_INFO, 8'h01, 32'h1, 2'h2, 32'h0);
    op(1'b1, lswhw_pkg::IDX_OP_COND, 8'h01, 32'h1, 2'h2, 32'h0);
    for (int s = 1; s <= 5; s++)
      op(1'b0, lswhw_pkg::IDX_OP_COND, 8'(s), 32'h0, 2'h0, meas[s - 1]);
    `CHK(tx_power_mv, meas[0])
    `CHK(tx_logic_mv, meas[1])
    op(1'b0, 16'h4015, 8'h00, 32'h0, 2'h1, 32'h0);
    op(1'b0, lswhw_pkg::IDX_OP_COND, 8'h06, 32'h0, 2'h1, 32'h0);
    op(1'b1, lswhw_pkg::IDX_HW_CONFIG, 8'h01, 32'h5a5a0001, 2'h0, 32'h0);
    op(1'b0, lswhw_pkg::IDX_HW_CONFIG, 8'h01, 32'h0, 2'h0, 32'h5a5a0001);
    `CHK(hardware_config_word, 32'h5a5a0001)
    op(1'b1, lswhw_pkg::IDX_LIMIT_REACT, 8'h00, 32'h00008000, 2'h0, 32'h0);
    op(1'b0, lswhw_pkg::IDX_LIMIT_REACT, 8'h00, 32'h0, 2'h0, 32'hffff8000);
    foreach (codes[k]) react(codes[k]);
    complete_run();
  end
endmodule // test_lswhw_top
